// >>> pkg/ccr_pkg.sv
/*
 * Constants for the configuration commit block of the metering core:
 * register addresses, field widths, reset values and timing counts.
 * Assumes a 25 MHz core clock and a 16-bit register address space.
 */
// Contract
// - With run set after reset, dividers, sag level and timeout apply once their hold, where present, ends.
// - Affected revision holds new divider one until first falling edge on pulse one.
// - Dividers two and three are held likewise, released by their own pulse pin.
// - Revision four silicon applies the dividers without that hold.
// - New sag level is held until some phase voltage exceeds ten percent scale.
// - New zero-cross timeout is held until some phase voltage exceeds ten percent.
// - Core recomputes power and rms results in a 125 us loop.
// - Rms read starting under 265 us after another may corrupt until next loop.
// - Hazard holds for any port; all other registers are unrestricted.
// - Select location reads back 0x01 after a correct unlock sequence.
// - Read-only 8-bit die revision register sits at 0xE707.
package ccr_pkg;

	// ------------------------------------------------------------
	// Addresses
	// ------------------------------------------------------------
	localparam int          ADDR_W         = 16;
	localparam int          DATA_W         = 32;
	localparam logic [15:0] ADDR_RUN       = 16'h0100;
	localparam logic [15:0] ADDR_DIV_BASE  = 16'h0101;
	localparam logic [15:0] ADDR_SAG       = 16'h0104;
	localparam logic [15:0] ADDR_ZX        = 16'h0105;
	localparam logic [15:0] ADDR_RMS_BASE  = 16'h43C0;
	localparam logic [15:0] ADDR_VERSION   = 16'hE707;
	localparam logic [15:0] ADDR_ACC_SEL   = 16'hE7E2;
	localparam logic [15:0] ADDR_ACC_KEY   = 16'hE7FE;

	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int          NUM_PULSE      = 3;
	localparam int          NUM_RMS        = 7;
	localparam int          NUM_PHASE      = 3;
	localparam int          DIV_W          = 16;
	localparam int          SAG_W          = 24;
	localparam int          ZX_W           = 16;
	localparam int          RMS_W          = 24;
	localparam int          RUN_BIT        = 0;
	localparam int          SWRST_BIT      = 1;
	localparam logic [15:0] DIV_RST        = 16'h0000;
	localparam logic [23:0] SAG_RST        = 24'h000000;
	localparam logic [15:0] ZX_RST         = 16'hFFFF;
	localparam logic [7:0]  ACC_RST        = 8'h00;
	localparam logic [7:0]  UNLOCK_KEY     = 8'hAD;
	localparam logic [7:0]  ACC_ENABLE     = 8'h01;
	localparam logic [7:0]  REV_AFFECTED   = 8'h02;
	localparam logic [7:0]  REV_FIXED      = 8'h04;
	localparam logic [23:0] FULL_SCALE_RST = 24'h400000;
	localparam int          THR_PERCENT    = 10;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          CLK_MHZ        = 25;
	localparam int          LOOP_US        = 125;
	localparam int          LOOP_CYC       = LOOP_US * CLK_MHZ;
	localparam int          RMS_GAP_US     = 265;
	localparam int          RMS_GAP_CYC    = RMS_GAP_US * CLK_MHZ;

endpackage

// >>> sim/ccr_commit_properties.sv
/* Checker bound to the config commit block's ports.
   Assumes one clock, a synchronous active-low reset and the revision of the bound block. */
`timescale 1ns/1ps
`default_nettype none
module ccr_commit_chk #(
	parameter logic [7:0] REVISION = ccr_pkg::REV_AFFECTED,
	parameter int LOOP_CYC    = 16,
	parameter int RMS_GAP_CYC = 20
) (
	input wire logic             core_clk_i,
	input wire logic             rst_b_i,
	input wire logic             wr_en_i,
	input wire logic             rd_en_i,
	input wire logic [15:0]      addr_i,
	input wire logic [31:0]      wdata_i,
	input wire logic [2:0]       pulse_out_i,
	input wire logic [2:0][23:0] phase_v_i,
	input wire logic [31:0]      rdata_o,
	input wire logic             rvalid_o,
	input wire logic             run_o,
	input wire logic [2:0][15:0] div_o,
	input wire logic [23:0]      sag_level_o,
	input wire logic [15:0]      zx_timeout_o,
	input wire logic [7:0]       acc_sel_o,
	input wire logic             loop_tick_o,
	input wire logic             rms_corrupt_o
);
	localparam int          LOOP_M1 = LOOP_CYC - 1;
	localparam logic [23:0] THR     = ccr_pkg::FULL_SCALE_RST / 24'h00000A;
	logic        rd_ok, rms_rd, early, hi, v_r, swr;
	logic [15:0] gap_r;
	logic [2:0]  prev_r, rel_r;
	assign rd_ok  = rd_en_i && !wr_en_i;
	assign rms_rd = rd_ok && addr_i >= ccr_pkg::ADDR_RMS_BASE && addr_i < ccr_pkg::ADDR_RMS_BASE + 16'h0007;
	assign early  = rms_rd && gap_r != 16'h0000 && gap_r < 16'(RMS_GAP_CYC);
	assign hi     = run_o && (phase_v_i[0] > THR || phase_v_i[1] > THR || phase_v_i[2] > THR);
	assign swr    = wr_en_i && addr_i == ccr_pkg::ADDR_RUN && wdata_i[ccr_pkg::SWRST_BIT];
	// Gap counts cycles since the last rms read start and saturates, so it stays small.
	// A software reset forgets all history, just as the block does.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			{gap_r, prev_r, rel_r, v_r} <= 23'h000000;
		end else if (swr) begin
			{gap_r, rel_r, v_r} <= 20'h00000;
			prev_r              <= pulse_out_i;
		end else begin
			gap_r  <= rms_rd ? 16'h0001 : (gap_r != 16'h0000 && gap_r < 16'(RMS_GAP_CYC)) ? gap_r + 16'h0001 : gap_r;
			prev_r <= pulse_out_i;
			rel_r  <= rel_r | (prev_r & ~pulse_out_i & {3{run_o}});
			v_r    <= v_r | hi;
		end
	end
	sequence s_key;
		wr_en_i && addr_i == ccr_pkg::ADDR_ACC_KEY && wdata_i[7:0] == ccr_pkg::UNLOCK_KEY;
	endsequence
	sequence s_sel;
		wr_en_i && addr_i == ccr_pkg::ADDR_ACC_SEL;
	endsequence
	default clocking dc @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	chk_read_answer: assert property (rd_ok |=> rvalid_o) else $error("read without answer");
	chk_answer_cause: assert property (rvalid_o |-> $past(rd_ok)) else $error("answer without read");
	chk_unlock_take: assert property (s_key ##1 s_sel |=> acc_sel_o == $past(wdata_i[7:0]))
		else $error("unlock not taken");
	chk_loop_period: assert property (loop_tick_o |=> !loop_tick_o ##LOOP_M1 loop_tick_o)
		else $error("loop period wrong");
	chk_rms_guard: assert property (early |=> rms_corrupt_o && rdata_o == 32'h00000000)
		else $error("close rms read not flagged");
	chk_rms_clear: assert property ($fell(rms_corrupt_o) |-> loop_tick_o || $past(swr))
		else $error("corrupt flag cleared off tick");
	chk_sag_held: assert property ($changed(sag_level_o) |-> v_r || $past(swr))
		else $error("sag level taken early");
	chk_zx_held: assert property ($changed(zx_timeout_o) |-> v_r || $past(swr))
		else $error("timeout taken early");
	chk_div_take: assert property (wr_en_i && addr_i == ccr_pkg::ADDR_DIV_BASE && run_o && rel_r[0]
		|-> ##2 div_o[0] == $past(wdata_i[15:0], 2)) else $error("divider not applied");
	for (genvar i = 0; i < 3; i++) begin : g_div
		chk_div_held: assert property ($changed(div_o[i]) |->
			rel_r[i] || $past(swr) || REVISION == ccr_pkg::REV_FIXED) else $error("divider taken early");
	end
endmodule
bind ccr_config_commit ccr_commit_chk #(.REVISION(REVISION), .LOOP_CYC(LOOP_CYC), .RMS_GAP_CYC(RMS_GAP_CYC))
	u_chk (.*);
`default_nettype wire

// >>> sim/ccr_host_model.sv
/* Host model on the register port: single accesses, repeated writes, the unlock pair.
   Assumes reads are answered one cycle after the read edge. */
`timescale 1ns/1ps
`default_nettype none
module ccr_host_model (
	input  wire logic        core_clk_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic        rvalid_i,
	output logic             wr_en_o,
	output logic             rd_en_o,
	output logic      [15:0] addr_o,
	output logic      [31:0] wdata_o
);
	initial {wr_en_o, rd_en_o, addr_o, wdata_o} = {2'b00, 16'hFFFF, 32'hFFFFFFFF};
	// Released lines carry the inverse of the last value, so a stale bus never matches.
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q, output logic v);
		@(posedge core_clk_i);
		#1;
		{wr_en_o, rd_en_o, addr_o, wdata_o} = {w, !w, a, d};
		@(posedge core_clk_i);
		#1;
		{wr_en_o, rd_en_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
		q = rdata_i;
		v = rvalid_i;
	endtask
	task automatic rd_rms(input int idx, input int gap, output logic [31:0] q, output logic v);
		repeat (gap) @(posedge core_clk_i);
		acc(1'b0, ccr_pkg::ADDR_RMS_BASE + 16'(idx), 32'h00000000, q, v);
	endtask
	task automatic wr8(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        v;
		repeat (8) acc(1'b1, a, d, q, v);
	endtask
	// Key and select sit on consecutive edges; any access between them voids the key.
	task automatic unlock(input logic [7:0] sel);
		@(posedge core_clk_i);
		#1;
		{wr_en_o, addr_o, wdata_o} = {1'b1, ccr_pkg::ADDR_ACC_KEY, 24'h000000, ccr_pkg::UNLOCK_KEY};
		@(posedge core_clk_i);
		#1;
		{addr_o, wdata_o} = {ccr_pkg::ADDR_ACC_SEL, 24'h000000, sel};
		@(posedge core_clk_i);
		#1;
		{wr_en_o, addr_o, wdata_o} = {1'b0, ~addr_o, ~wdata_o};
	endtask
endmodule
`default_nettype wire

// >>> sim/test_config_commit_and_access_rules.sv
/* Self-checking bench for the config commit block, host model on its register port.
   Assumes the package and the bound checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module test_config_commit_and_access_rules;
	localparam int          LOOP = 16;
	localparam int          GAP  = 20;
	localparam logic [23:0] THR  = ccr_pkg::FULL_SCALE_RST / 24'h00000A;
	logic             core_clk_i, rst_b_i, wr_en_i, rd_en_i, rvalid_o, run_o, loop_tick_o, rms_corrupt_o, v;
	logic [15:0]      addr_i, zx_timeout_o;
	logic [31:0]      wdata_i, rdata_o, q;
	logic [2:0]       pulse_out_i;
	logic [2:0][23:0] phase_v_i;
	logic [6:0][23:0] rms_i;
	logic [2:0][15:0] div_o, div_fix;
	logic [23:0]      sag_level_o;
	logic [7:0]       acc_sel_o;
	int               fails = 0, num_checks = 0, n;
	ccr_config_commit #(.LOOP_CYC(LOOP), .RMS_GAP_CYC(GAP)) uut (.*);
	ccr_host_model host (.core_clk_i(core_clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o), .wr_en_o(wr_en_i),
		.rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
	// A second block of the fixed revision shares the stimulus, so the two hold behaviours are compared.
	ccr_config_commit #(.REVISION(ccr_pkg::REV_FIXED), .LOOP_CYC(LOOP), .RMS_GAP_CYC(GAP)) uut_fix (
		.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .pulse_out_i(pulse_out_i), .phase_v_i(phase_v_i), .rms_i(rms_i), .rdata_o(),
		.rvalid_o(), .run_o(), .div_o(div_fix), .sag_level_o(), .zx_timeout_o(), .acc_sel_o(), .loop_tick_o(),
		.rms_corrupt_o());
	always #20 core_clk_i = ~core_clk_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		chk({31'h00000000, got}, {31'h00000000, exp});
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		host.acc(1'b0, a, 32'h00000000, q, v);
		chk_flag(v, 1'b1);
		chk(q, exp);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		host.acc(1'b1, a, d, q, v);
	endtask
	task automatic settle(input int k);
		repeat (k) @(posedge core_clk_i);
		#1;
	endtask
	task automatic wait_tick;
		n = 0;
		do begin
			settle(1);
			n++;
		end while (loop_tick_o !== 1'b1 && n < 100);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// The run needs about two hundred cycles; the limit is twenty-five times that.
	initial begin
		#200000;
		fails++;
		close_out;
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		core_clk_i  = 1'b0;
		rst_b_i     = 1'b0;
		pulse_out_i = 3'h7;
		phase_v_i   = {3{24'h000000}};
		for (int i = 0; i < 7; i++) rms_i[i] = 24'h0A0000 + 24'(i);
		settle(2);
		rst_b_i = 1'b1;
		for (int i = 0; i < 3; i++) chk({16'h0000, div_o[i]}, {16'h0000, ccr_pkg::DIV_RST});
		chk({8'h00, sag_level_o}, {8'h00, ccr_pkg::SAG_RST});
		chk({16'h0000, zx_timeout_o}, {16'h0000, ccr_pkg::ZX_RST});
		chk({24'h000000, acc_sel_o}, {24'h000000, ccr_pkg::ACC_RST});
		rd(ccr_pkg::ADDR_VERSION, {24'h000000, ccr_pkg::REV_AFFECTED});
		wr(ccr_pkg::ADDR_VERSION, 32'h000000FF);
		rd(ccr_pkg::ADDR_VERSION, {24'h000000, ccr_pkg::REV_AFFECTED});
		rd(16'h0200, 32'h00000000);
		$display("test reset values done");
		wr(ccr_pkg::ADDR_RUN, 32'h00000001);
		chk_flag(run_o, 1'b1);
		wr(ccr_pkg::ADDR_DIV_BASE, 32'h00001234);
		host.wr8(ccr_pkg::ADDR_DIV_BASE + 16'h0001, 32'h00002345);
		wr(ccr_pkg::ADDR_DIV_BASE + 16'h0002, 32'h00003456);
		host.wr8(ccr_pkg::ADDR_SAG, 32'h00123456);
		wr(ccr_pkg::ADDR_ZX, 32'h0000ABCD);
		rd(ccr_pkg::ADDR_DIV_BASE, 32'h00001234);
		phase_v_i[1] = THR;
		settle(3);
		chk({16'h0000, div_o[0]}, 32'h00000000);
		chk({8'h00, sag_level_o}, 32'h00000000);
		chk({16'h0000, zx_timeout_o}, 32'h0000FFFF);
		chk({div_fix[1], div_fix[0]}, 32'h23451234);
		pulse_out_i = 3'h6;
		settle(3);
		chk({div_o[1], div_o[0]}, 32'h00001234);
		pulse_out_i = 3'h0;
		settle(3);
		chk({div_o[2], div_o[1]}, 32'h34562345);
		phase_v_i[1] = THR + 24'h000001;
		settle(3);
		chk({8'h00, sag_level_o}, 32'h00123456);
		chk({16'h0000, zx_timeout_o}, 32'h0000ABCD);
		wr(ccr_pkg::ADDR_DIV_BASE, 32'h00000042);
		settle(1);
		chk({16'h0000, div_o[0]}, 32'h00000042);
		$display("test commit hold done");
		wr(ccr_pkg::ADDR_ACC_KEY, {24'h000000, ccr_pkg::UNLOCK_KEY});
		rd(ccr_pkg::ADDR_ACC_KEY, 32'h00000000);
		wr(ccr_pkg::ADDR_ACC_SEL, {24'h000000, ccr_pkg::ACC_ENABLE});
		chk({24'h000000, acc_sel_o}, 32'h00000000);
		host.unlock(ccr_pkg::ACC_ENABLE);
		rd(ccr_pkg::ADDR_ACC_SEL, {24'h000000, ccr_pkg::ACC_ENABLE});
		chk({24'h000000, acc_sel_o}, {24'h000000, ccr_pkg::ACC_ENABLE});
		$display("test unlock done");
		host.rd_rms(4, GAP, q, v);
		chk(q, {8'h00, rms_i[4]});
		host.rd_rms(5, GAP - 2, q, v);
		chk(q, {8'h00, rms_i[5]});
		host.rd_rms(6, GAP - 4, q, v);
		chk(q, 32'h00000000);
		chk_flag(rms_corrupt_o, 1'b1);
		wait_tick;
		wait_tick;
		chk(n, LOOP);
		chk_flag(rms_corrupt_o, 1'b0);
		rd(ccr_pkg::ADDR_VERSION, {24'h000000, ccr_pkg::REV_AFFECTED});
		host.rd_rms(0, GAP - 2, q, v);
		chk(q, {8'h00, rms_i[0]});
		$display("test rms spacing done");
		wr(ccr_pkg::ADDR_RUN, 32'h00000002);
		chk_flag(run_o, 1'b0);
		chk({16'h0000, div_o[0]}, {16'h0000, ccr_pkg::DIV_RST});
		chk({16'h0000, zx_timeout_o}, {16'h0000, ccr_pkg::ZX_RST});
		chk({24'h000000, acc_sel_o}, {24'h000000, ccr_pkg::ACC_RST});
		wr(ccr_pkg::ADDR_RUN, 32'h00000001);
		wr(ccr_pkg::ADDR_DIV_BASE, 32'h00000077);
		settle(1);
		chk({16'h0000, div_o[0]}, 32'h00000000);
		chk({16'h0000, div_fix[0]}, 32'h00000077);
		$display("test software reset done");
		close_out;
	end
endmodule
`default_nettype wire

// >>> verilog/ccr_config_commit.sv
/*
 * Configuration commit and access control of the metering core: holds the
 * written pulse dividers, sag level and zero-cross timeout, decides when the
 * datapath takes them up, guards rms reads and the accuracy unlock sequence.
 * Assumes a same-clock register port with one access per cycle, pulse outputs
 * and phase voltage magnitudes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ccr_config_commit #(
	parameter logic [7:0]  REVISION    = ccr_pkg::REV_AFFECTED,
	parameter logic [23:0] FULL_SCALE  = ccr_pkg::FULL_SCALE_RST,
	parameter int          LOOP_CYC    = ccr_pkg::LOOP_CYC,
	parameter int          RMS_GAP_CYC = ccr_pkg::RMS_GAP_CYC
) (
	input  wire logic                                        core_clk_i,
	input  wire logic                                        rst_b_i,
	input  wire logic                                        wr_en_i,
	input  wire logic                                        rd_en_i,
	input  wire logic [ccr_pkg::ADDR_W-1:0]                  addr_i,
	input  wire logic [ccr_pkg::DATA_W-1:0]                  wdata_i,
	input  wire logic [ccr_pkg::NUM_PULSE-1:0]               pulse_out_i,
	input  wire logic [ccr_pkg::NUM_PHASE-1:0][23:0]         phase_v_i,
	input  wire logic [ccr_pkg::NUM_RMS-1:0][ccr_pkg::RMS_W-1:0] rms_i,
	output logic      [ccr_pkg::DATA_W-1:0]                  rdata_o,
	output logic                                             rvalid_o,
	output logic                                             run_o,
	output logic      [ccr_pkg::NUM_PULSE-1:0][ccr_pkg::DIV_W-1:0] div_o,
	output logic      [ccr_pkg::SAG_W-1:0]                   sag_level_o,
	output logic      [ccr_pkg::ZX_W-1:0]                    zx_timeout_o,
	output logic      [7:0]                                  acc_sel_o,
	output logic                                             loop_tick_o,
	output logic                                             rms_corrupt_o
);

	// ------------------------------------------------------------
	// Elaboration checks and derived constants
	// ------------------------------------------------------------
	if (REVISION != ccr_pkg::REV_AFFECTED && REVISION != ccr_pkg::REV_FIXED) begin : g_chk_rev
		$error("Only the two known die revisions are modelled.");
	end
	if (RMS_GAP_CYC < 2 || LOOP_CYC < 2) begin : g_chk_time
		$error("Timing counts must be at least two cycles.");
	end

	localparam int          GW       = $clog2(RMS_GAP_CYC + 1);
	localparam logic [23:0] V_THRESH = 24'(int'(FULL_SCALE) / ccr_pkg::THR_PERCENT);
	localparam logic        DIV_HOLD = (REVISION == ccr_pkg::REV_AFFECTED);

	typedef struct packed {
		logic                                             run;
		logic [ccr_pkg::NUM_PULSE-1:0][ccr_pkg::DIV_W-1:0] div_sh;
		logic [ccr_pkg::NUM_PULSE-1:0][ccr_pkg::DIV_W-1:0] div_act;
		logic [ccr_pkg::NUM_PULSE-1:0]                    div_fresh;
		logic [ccr_pkg::NUM_PULSE-1:0]                    pulse_prev;
		logic [ccr_pkg::SAG_W-1:0]                        sag_sh;
		logic [ccr_pkg::SAG_W-1:0]                        sag_act;
		logic [ccr_pkg::ZX_W-1:0]                         zx_sh;
		logic [ccr_pkg::ZX_W-1:0]                         zx_act;
		logic                                             volt_fresh;
		logic                                             key_armed;
		logic [7:0]                                       acc_sel;
		logic [ccr_pkg::DATA_W-1:0]                       rdata;
		logic                                             rvalid;
		logic [GW-1:0]                                    gap_cnt;
		logic                                             rms_seen;
		logic                                             corrupt;
		logic                                             loop_tick;
	} ccr_state_t;

	ccr_state_t st_r;
	ccr_state_t st_nxt;
	logic       tmr_tick;

	// ------------------------------------------------------------
	// Address decoding
	// ------------------------------------------------------------
	function automatic logic is_rms(input logic [ccr_pkg::ADDR_W-1:0] a);
		is_rms = (a >= ccr_pkg::ADDR_RMS_BASE) &&
		         (a < ccr_pkg::ADDR_RMS_BASE + 16'(ccr_pkg::NUM_RMS));
	endfunction

	function automatic logic is_div(input logic [ccr_pkg::ADDR_W-1:0] a);
		is_div = (a >= ccr_pkg::ADDR_DIV_BASE) &&
		         (a < ccr_pkg::ADDR_DIV_BASE + 16'(ccr_pkg::NUM_PULSE));
	endfunction

	function automatic ccr_state_t reset_state();
		ccr_state_t s;
		s            = '0;
		s.div_sh     = {ccr_pkg::NUM_PULSE{ccr_pkg::DIV_RST}};
		s.div_act    = {ccr_pkg::NUM_PULSE{ccr_pkg::DIV_RST}};
		s.div_fresh  = '1;
		s.sag_sh     = ccr_pkg::SAG_RST;
		s.sag_act    = ccr_pkg::SAG_RST;
		s.zx_sh      = ccr_pkg::ZX_RST;
		s.zx_act     = ccr_pkg::ZX_RST;
		s.volt_fresh = 1'b1;
		s.acc_sel    = ccr_pkg::ACC_RST;
		s.gap_cnt    = GW'(RMS_GAP_CYC);
		return s;
	endfunction

	// ------------------------------------------------------------
	// Loop timer
	// ------------------------------------------------------------
	ccr_loop_timer #(
		.PERIOD (LOOP_CYC)
	) u_loop_timer (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.tick_o     (tmr_tick)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic       wr;
		logic       rd;
		logic       volt_high;
		logic [1:0] idx;
		logic [2:0] ridx;
		wr        = wr_en_i;
		rd        = rd_en_i && !wr_en_i;
		volt_high = 1'b0;
		idx       = 2'(addr_i - ccr_pkg::ADDR_DIV_BASE);
		ridx      = 3'(addr_i - ccr_pkg::ADDR_RMS_BASE);
		st_nxt           = st_r;
		st_nxt.rvalid    = 1'b0;
		st_nxt.loop_tick = tmr_tick;
		st_nxt.pulse_prev = pulse_out_i;

		for (int p = 0; p < ccr_pkg::NUM_PHASE; p++) begin
			if (phase_v_i[p] > V_THRESH) begin
				volt_high = 1'b1;
			end
		end

		// Divider, sag and timeout writes land in the shadow copies; the datapath sees them only once committed.
		if (wr) begin
			if (addr_i == ccr_pkg::ADDR_RUN) begin
				st_nxt.run = wdata_i[ccr_pkg::RUN_BIT];
			end
			if (is_div(addr_i)) begin
				st_nxt.div_sh[idx] = wdata_i[ccr_pkg::DIV_W-1:0];
			end
			if (addr_i == ccr_pkg::ADDR_SAG) begin
				st_nxt.sag_sh = wdata_i[ccr_pkg::SAG_W-1:0];
			end
			if (addr_i == ccr_pkg::ADDR_ZX) begin
				st_nxt.zx_sh = wdata_i[ccr_pkg::ZX_W-1:0];
			end
			if (addr_i == ccr_pkg::ADDR_ACC_SEL && st_r.key_armed) begin
				st_nxt.acc_sel = wdata_i[7:0];
			end
		end

		// Any access other than the key write disarms, so a stray access breaks the pair.
		if (wr && addr_i == ccr_pkg::ADDR_ACC_KEY && wdata_i[7:0] == ccr_pkg::UNLOCK_KEY) begin
			st_nxt.key_armed = 1'b1;
		end else if (wr || rd) begin
			st_nxt.key_armed = 1'b0;
		end

		// Release events for the held values.
		for (int i = 0; i < ccr_pkg::NUM_PULSE; i++) begin
			if (st_r.run && st_r.pulse_prev[i] && !pulse_out_i[i]) begin
				st_nxt.div_fresh[i] = 1'b0;
			end
		end
		if (st_r.run && volt_high) begin
			st_nxt.volt_fresh = 1'b0;
		end

		// Commit shadow to the datapath while running and not held.
		if (st_r.run) begin
			for (int i = 0; i < ccr_pkg::NUM_PULSE; i++) begin
				if (!(DIV_HOLD && st_r.div_fresh[i])) begin
					st_nxt.div_act[i] = st_r.div_sh[i];
				end
			end
			if (!st_r.volt_fresh) begin
				st_nxt.sag_act = st_r.sag_sh;
				st_nxt.zx_act  = st_r.zx_sh;
			end
		end

		// Rms read spacing watch; corruption recovers at the next loop boundary.
		if (st_r.gap_cnt != GW'(RMS_GAP_CYC)) begin
			st_nxt.gap_cnt = st_r.gap_cnt + 1'b1;
		end
		if (tmr_tick) begin
			st_nxt.corrupt = 1'b0;
		end
		if (rd && is_rms(addr_i)) begin
			// Starting at one makes the count equal the cycles between read starts.
			st_nxt.gap_cnt  = GW'(1);
			st_nxt.rms_seen = 1'b1;
			if (st_r.rms_seen && st_r.gap_cnt < GW'(RMS_GAP_CYC)) begin
				st_nxt.corrupt = 1'b1;
			end
		end

		// Read data; every non-rms register answers without restriction.
		if (rd) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = '0;
			if (is_rms(addr_i)) begin
				if (!(st_r.rms_seen && st_r.gap_cnt < GW'(RMS_GAP_CYC))) begin
					st_nxt.rdata = 32'(rms_i[ridx]);
				end
			end else if (is_div(addr_i)) begin
				st_nxt.rdata = 32'(st_r.div_sh[idx]);
			end else if (addr_i == ccr_pkg::ADDR_RUN) begin
				st_nxt.rdata = 32'(st_r.run);
			end else if (addr_i == ccr_pkg::ADDR_SAG) begin
				st_nxt.rdata = 32'(st_r.sag_sh);
			end else if (addr_i == ccr_pkg::ADDR_ZX) begin
				st_nxt.rdata = 32'(st_r.zx_sh);
			end else if (addr_i == ccr_pkg::ADDR_ACC_SEL) begin
				st_nxt.rdata = 32'(st_r.acc_sel);
			end else if (addr_i == ccr_pkg::ADDR_VERSION) begin
				st_nxt.rdata = 32'(REVISION);
			end
		end

		// A software reset reloads the hardware reset state, except that the loop timer runs on and the pulse history takes the current pulse inputs.
		if (wr && addr_i == ccr_pkg::ADDR_RUN && wdata_i[ccr_pkg::SWRST_BIT]) begin
			st_nxt           = reset_state();
			st_nxt.loop_tick = tmr_tick;
			st_nxt.pulse_prev = pulse_out_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			st_r <= reset_state();
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdata_o       = st_r.rdata;
	assign rvalid_o      = st_r.rvalid;
	assign run_o         = st_r.run;
	assign div_o         = st_r.div_act;
	assign sag_level_o   = st_r.sag_act;
	assign zx_timeout_o  = st_r.zx_act;
	assign acc_sel_o     = st_r.acc_sel;
	assign loop_tick_o   = st_r.loop_tick;
	assign rms_corrupt_o = st_r.corrupt;

endmodule

`default_nettype wire

// >>> verilog/ccr_loop_timer.sv
/*
 * Free-running loop timer: one-cycle tick at the end of every period.
 * Assumes a synchronous active-low reset on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ccr_loop_timer #(
	parameter int PERIOD = ccr_pkg::LOOP_CYC
) (
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	output logic      tick_o
);

	localparam int CW = $clog2(PERIOD);

	if (PERIOD < 2) begin : g_chk
		$error("Loop period must be at least two cycles.");
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} ccr_tmr_t;

	ccr_tmr_t st_r;
	ccr_tmr_t st_nxt;

	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt == CW'(PERIOD - 1)) begin
			st_nxt.cnt  = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick_o = st_r.tick;

endmodule

`default_nettype wire
